// File: amp_comparator_pkg.sv
/*
  Constants shared by the amplifier/comparator control block: register
  indices and byte addresses, field positions, reset values and mode codes.
  Assumes a 32-bit APB bus where each register takes one aligned word.
*/
package amp_comparator_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  // Printed offsets are indices; the byte address is four times each
  localparam logic [7:0]  PIN_SELECT_INDEX = 8'hF6;
  localparam logic [7:0]  CONTROL0_INDEX   = 8'hFE;
  localparam logic [7:0]  CONTROL1_INDEX   = 8'hFF;
  localparam logic [11:0] PIN_SELECT_ADDR  = {2'h0, PIN_SELECT_INDEX, 2'h0};
  localparam logic [11:0] CONTROL0_ADDR    = {2'h0, CONTROL0_INDEX, 2'h0};
  localparam logic [11:0] CONTROL1_ADDR    = {2'h0, CONTROL1_INDEX, 2'h0};
  localparam int          ADDR_W_MIN       = 12;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  // Pin-select nibble of unit u starts at bit NIBBLE_W*(1-u)
  localparam int          NIBBLE_W       = 4;
  localparam int          AMP_BIT        = 3;
  localparam int          COMP_BIT       = 2;
  localparam int          INT_REF_BIT    = 1;
  localparam int          EXT_PIN_BIT    = 0;
  // Comparator control register
  localparam int          HYS_BIT        = 7;
  localparam int          RESULT_BIT     = 6;
  localparam int          EDGE_MODE_LSB  = 4;
  localparam int          FLAG_BIT       = 3;
  localparam int          ROUTE_BIT      = 0;
  localparam logic [7:0]  PIN_SELECT_RST = 8'h00;
  localparam logic [1:0]  EDGE_MODE_RST  = 2'h0;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_GPIO = 2'b00,
    MODE_COMP = 2'b01,
    MODE_AMP  = 2'b10
  } unit_mode_e;

  typedef enum logic [1:0] {
    EDGE_TOGGLE   = 2'b00,
    EDGE_RISE     = 2'b01,
    EDGE_FALL     = 2'b10,
    EDGE_RESERVED = 2'b11
  } edge_mode_e;

  typedef enum logic [1:0] {
    SEL_PIN   = 2'b00,
    SEL_CTRL0 = 2'b01,
    SEL_CTRL1 = 2'b10,
    SEL_NONE  = 2'b11
  } reg_sel_e;

endpackage

// File: amp_comparator_control.sv
/*
  Control logic for two amplifier/comparator units behind an APB slave.
  Assumes the analog circuits, the pin multiplexers and the converter input
  mux act on the level outputs below, and that comp_raw comes straight from
  the analog comparators, asynchronous to sys_clk.
*/
// The APB interface to the registers was left to the implementer.
// What this block does
// - Amplifier wins when both unit enables set
// - Unit 0 enable takes its three pins analog
// - Unit 1 enable takes its three pins analog
// - Both enables clear: pins stay general purpose
// - Internal reference select picks the reference whenever the unit is enabled
// - External select alone picks the positive pin
// - Hysteresis bit switches hysteresis, resets off
// - Compare result bit is read only
// - Two-bit mode picks toggle, rise or fall
// - Flag sticks until software clears it
// - Unit 1 has its own edge mode
// - Route bit sends amplifier 0 to extra channel
// - All three registers reset to zero
module amp_comparator_control #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Analog comparator results, one per unit
  input  wire logic [1:0]        comp_raw,
  // Analog controls, index is the unit number
  output logic      [1:0]        amp_on,
  output logic      [1:0]        comp_on,
  output logic      [1:0]        pins_analog,
  output logic      [1:0]        ref_internal,
  output logic      [1:0]        ref_external,
  output logic      [1:0]        hysteresis_on,
  output logic                   amp0_extra_converter_route
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (ADDR_W < amp_comparator_pkg::ADDR_W_MIN || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must lie between 12 and 32");
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Address decode, shared by read and write paths
  function automatic amp_comparator_pkg::reg_sel_e decode_reg(input logic [ADDR_W-1:0] addr);
    if (addr == ADDR_W'(amp_comparator_pkg::PIN_SELECT_ADDR)) begin
      decode_reg = amp_comparator_pkg::SEL_PIN;
    end else if (addr == ADDR_W'(amp_comparator_pkg::CONTROL0_ADDR)) begin
      decode_reg = amp_comparator_pkg::SEL_CTRL0;
    end else if (addr == ADDR_W'(amp_comparator_pkg::CONTROL1_ADDR)) begin
      decode_reg = amp_comparator_pkg::SEL_CTRL1;
    end else begin
      decode_reg = amp_comparator_pkg::SEL_NONE;
    end
  endfunction

  // Operating mode of one unit from its amplifier and comparator enables
  function automatic amp_comparator_pkg::unit_mode_e unit_mode(input logic amp, input logic comp);
    if (amp) begin
      unit_mode = amp_comparator_pkg::MODE_AMP;
    end else if (comp) begin
      unit_mode = amp_comparator_pkg::MODE_COMP;
    end else begin
      unit_mode = amp_comparator_pkg::MODE_GPIO;
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]       pin_select_reg;
  logic [1:0]       edge_mode_reg [2];
  logic [1:0]       flag_reg;
  logic [1:0]       meta_reg;
  logic [1:0]       sync_reg;
  logic [1:0]       prev_reg;
  logic [1:0]       hw_event;
  logic [1:0]       sw_clear;
  logic [1:0]       wr_ctrl;
  logic [3:0]       nibble [2];
  logic [7:0]       ctrl_view [2];
  logic             setup_phase;
  logic             access_done;
  logic             wr_pin;
  amp_comparator_pkg::reg_sel_e sel;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // A write lands only at the edge that completes the access phase
  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign sel         = decode_reg(paddr);
  assign wr_pin      = access_done & pwrite & (sel == amp_comparator_pkg::SEL_PIN);
  assign wr_ctrl[0]  = access_done & pwrite & (sel == amp_comparator_pkg::SEL_CTRL0);
  assign wr_ctrl[1]  = access_done & pwrite & (sel == amp_comparator_pkg::SEL_CTRL1);

  // ----------------------------------------------------------------
  // Per-unit combinational logic
  // ----------------------------------------------------------------
  for (genvar u = 0; u < 2; u++) begin : g_unit
    assign nibble[u] = pin_select_reg[amp_comparator_pkg::NIBBLE_W*(1-u) +: amp_comparator_pkg::NIBBLE_W];

    // Selected edge of the synchronised result, reserved code sets nothing
    always_comb begin
      case (edge_mode_reg[u])
        amp_comparator_pkg::EDGE_TOGGLE: hw_event[u] = sync_reg[u] ^ prev_reg[u];
        amp_comparator_pkg::EDGE_RISE:   hw_event[u] = sync_reg[u] & ~prev_reg[u];
        amp_comparator_pkg::EDGE_FALL:   hw_event[u] = ~sync_reg[u] & prev_reg[u];
        default:                         hw_event[u] = 1'b0;
      endcase
    end

    // Software clears by writing zero to the flag bit; writing one does nothing
    assign sw_clear[u] = wr_ctrl[u] & ~pwdata[amp_comparator_pkg::FLAG_BIT];

    // Read view; the result bit has no storage, so writes cannot touch it
    assign ctrl_view[u] = {hysteresis_on[u], sync_reg[u], edge_mode_reg[u], flag_reg[u], 2'h0,
                           (u == 0) ? amp0_extra_converter_route : 1'b0};
  end

  // ----------------------------------------------------------------
  // Pin-select register
  // ----------------------------------------------------------------
  // Software must keep legal source combinations; and
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_select_reg <= amp_comparator_pkg::PIN_SELECT_RST;
    end else if (wr_pin) begin
      pin_select_reg <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Comparator control registers
  // ----------------------------------------------------------------
  // Hysteresis, edge mode and route bits
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hysteresis_on              <= 2'h0;
      edge_mode_reg[0]           <= amp_comparator_pkg::EDGE_MODE_RST;
      edge_mode_reg[1]           <= amp_comparator_pkg::EDGE_MODE_RST;
      amp0_extra_converter_route <= 1'b0;
    end else begin
      for (int u = 0; u < 2; u++) begin
        if (wr_ctrl[u]) begin
          hysteresis_on[u] <= pwdata[amp_comparator_pkg::HYS_BIT];
          edge_mode_reg[u] <= pwdata[amp_comparator_pkg::EDGE_MODE_LSB +: 2];
        end
      end
      if (wr_ctrl[0]) begin
        amp0_extra_converter_route <= pwdata[amp_comparator_pkg::ROUTE_BIT];
      end
    end
  end

  // Sticky flags; a set in the clearing cycle wins so no event is lost
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= 2'h0;
    end else begin
      for (int u = 0; u < 2; u++) begin
        if (hw_event[u]) begin
          flag_reg[u] <= 1'b1;
        end else if (sw_clear[u]) begin
          flag_reg[u] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Comparator result synchroniser
  // ----------------------------------------------------------------
  // Only sync_reg and later stages are read; meta_reg may be metastable
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 2'h0;
      sync_reg <= 2'h0;
      prev_reg <= 2'h0;
    end else begin
      meta_reg <= comp_raw;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // ----------------------------------------------------------------
  // Analog control outputs
  // ----------------------------------------------------------------
  // Registered so the analog switches see clean levels, one cycle after the write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      amp_on       <= 2'h0;
      comp_on      <= 2'h0;
      pins_analog  <= 2'h0;
      ref_internal <= 2'h0;
      ref_external <= 2'h0;
    end else begin
      for (int u = 0; u < 2; u++) begin
        amp_on[u]       <= unit_mode(nibble[u][amp_comparator_pkg::AMP_BIT],
                                     nibble[u][amp_comparator_pkg::COMP_BIT]) == amp_comparator_pkg::MODE_AMP;
        comp_on[u]      <= unit_mode(nibble[u][amp_comparator_pkg::AMP_BIT],
                                     nibble[u][amp_comparator_pkg::COMP_BIT]) == amp_comparator_pkg::MODE_COMP;
        pins_analog[u]  <= nibble[u][amp_comparator_pkg::AMP_BIT] | nibble[u][amp_comparator_pkg::COMP_BIT];
        // Internal reference overrides the pin select
        ref_internal[u] <= (nibble[u][amp_comparator_pkg::AMP_BIT] | nibble[u][amp_comparator_pkg::COMP_BIT])
                           & nibble[u][amp_comparator_pkg::INT_REF_BIT];
        ref_external[u] <= (nibble[u][amp_comparator_pkg::AMP_BIT] | nibble[u][amp_comparator_pkg::COMP_BIT])
                           & nibble[u][amp_comparator_pkg::EXT_PIN_BIT]
                           & ~nibble[u][amp_comparator_pkg::INT_REF_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------
  // One wait-free access phase: data and ready are prepared in the setup cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase & (sel == amp_comparator_pkg::SEL_NONE);
      if (setup_phase && !pwrite) begin
        if (sel == amp_comparator_pkg::SEL_PIN) begin
          prdata <= {24'h0, pin_select_reg};
        end else if (sel == amp_comparator_pkg::SEL_CTRL0) begin
          prdata <= {24'h0, ctrl_view[0]};
        end else if (sel == amp_comparator_pkg::SEL_CTRL1) begin
          prdata <= {24'h0, ctrl_view[1]};
        end else begin
          prdata <= 32'h0;
        end
      end else if (setup_phase) begin
        prdata <= 32'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_amp_priority_u0: assert property (pin_select_reg[7] && pin_select_reg[6] |=> amp_on[0] && !comp_on[0])
    else $error("unit 0 amplifier lost priority");
  a_unit0_pins_analog: assert property (pin_select_reg[7] || pin_select_reg[6] |=> pins_analog[0])
    else $error("unit 0 pins not analog");
  a_unit1_pins_analog: assert property (pin_select_reg[3] || pin_select_reg[2] |=> pins_analog[1])
    else $error("unit 1 pins not analog");
  a_amp_priority_u1: assert property (pin_select_reg[3] && pin_select_reg[2] |=> amp_on[1] && !comp_on[1])
    else $error("unit 1 amplifier lost priority");
  a_gpio_when_off: assert property (
    !pin_select_reg[3] && !pin_select_reg[2]
    |=> !pins_analog[1] && !ref_internal[1] && !ref_external[1] && !amp_on[1])
    else $error("unit 1 left general purpose mode");
  a_unit0_gpio_off: assert property (
    !pin_select_reg[7] && !pin_select_reg[6]
    |=> !pins_analog[0] && !ref_internal[0] && !ref_external[0] && !comp_on[0])
    else $error("unit 0 left general purpose mode");
  a_internal_ref_wins: assert property (
    pin_select_reg[6] && pin_select_reg[5] && pin_select_reg[4]
    |=> ref_internal[0] && !ref_external[0])
    else $error("internal reference not selected");
  a_external_pin_src: assert property (
    pin_select_reg[3] && !pin_select_reg[1] && pin_select_reg[0]
    |=> ref_external[1] && !ref_internal[1])
    else $error("external pin not selected");
  // Software keeps the sources legal; the stored select shows whether it did
  a_unit0_has_source: assert property (
    pin_select_reg[7] || pin_select_reg[6] |-> pin_select_reg[5] || pin_select_reg[4])
    else $error("unit 0 enabled with no source");
  a_unit1_has_source: assert property (
    pin_select_reg[3] || pin_select_reg[2] |-> pin_select_reg[1] || pin_select_reg[0])
    else $error("unit 1 enabled with no source");
  a_unit0_one_source: assert property (
    pin_select_reg[7] |-> !(pin_select_reg[5] && pin_select_reg[4]))
    else $error("unit 0 amplifier with both sources");
  a_unit1_one_source: assert property (
    pin_select_reg[3] |-> !(pin_select_reg[1] && pin_select_reg[0]))
    else $error("unit 1 amplifier with both sources");
  a_hys_follows_write: assert property (wr_ctrl[1] |=> hysteresis_on[1] == $past(pwdata[7]))
    else $error("hysteresis bit not written");
  a_result_read_only: assert property (
    setup_phase && !pwrite && sel == amp_comparator_pkg::SEL_CTRL0
    |=> prdata[6] == $past(sync_reg[0]))
    else $error("result bit does not show comparator");
  a_result_unit1: assert property (
    setup_phase && !pwrite && sel == amp_comparator_pkg::SEL_CTRL1
    |=> prdata[6] == $past(sync_reg[1]))
    else $error("result bit does not show comparator 1");
  a_toggle_sets_flag: assert property (
    edge_mode_reg[0] == 2'b00 && sync_reg[0] != prev_reg[0]
    |=> flag_reg[0])
    else $error("toggle did not set flag 0");
  a_rise_sets_flag: assert property (
    edge_mode_reg[0] == 2'b01 && sync_reg[0] && !prev_reg[0]
    |=> flag_reg[0])
    else $error("rising edge did not set flag 0");
  a_unit1_rise_flag: assert property (
    edge_mode_reg[1] == 2'b01 && sync_reg[1] && !prev_reg[1]
    |=> flag_reg[1])
    else $error("rising edge did not set flag 1");
  a_fall_sets_flag: assert property (
    edge_mode_reg[1] == 2'b10 && !sync_reg[1] && prev_reg[1]
    |=> flag_reg[1])
    else $error("falling edge did not set flag 1");
  a_reserved_no_set: assert property (
    edge_mode_reg[0] == 2'b11 && !flag_reg[0] && !wr_ctrl[0]
    |=> !flag_reg[0])
    else $error("reserved mode set flag 0");
  a_flag_sticky: assert property (flag_reg[1] && !sw_clear[1] |=> flag_reg[1])
    else $error("flag 1 cleared without software");
  a_route_follows: assert property (wr_ctrl[0] |=> amp0_extra_converter_route == $past(pwdata[0]))
    else $error("route bit not written");
  a_reset_zero: assert property (
    !$past(rst_n) |-> pin_select_reg == 8'h00 && flag_reg == 2'h0
    && !pins_analog[0] && !pins_analog[1])
    else $error("registers not zero after reset");
  a_sync_two_stage: assert property (sync_reg[0] == $past(comp_raw[0], 2))
    else $error("result not delayed two stages");
  a_sync_unit1: assert property (sync_reg[1] == $past(comp_raw[1], 2))
    else $error("result 1 not delayed two stages");
  a_set_beats_clear: assert property (hw_event[0] && sw_clear[0] |=> flag_reg[0])
    else $error("clear beat a hardware set");

  c_flag_rise: cover property (edge_mode_reg[0] == 2'b01 && !flag_reg[0] ##1 flag_reg[0]);
  c_flag_fall: cover property (edge_mode_reg[1] == 2'b10 && !flag_reg[1] ##1 flag_reg[1]);
  c_amp_priority: cover property (pin_select_reg[3] && pin_select_reg[2] ##1 amp_on[1]);
  c_set_clear_clash: cover property (hw_event[0] && sw_clear[0]);
  c_unmapped_err: cover property (pslverr && pready);

endmodule

// File: analog_front_model.sv
/*
  Behavioural model of the two analog comparators that feed comp_raw.
  Assumes the bench sets pin voltages in millivolts, well clear of hysteresis.
*/
module analog_front_model (
  // Clock
  input  wire logic             sys_clk,
  // Controls from the block
  input  wire logic [1:0]       pins_analog,
  input  wire logic [1:0]       ref_internal,
  input  wire logic [1:0]       hysteresis_on,
  // Pin voltages in millivolts
  input  wire logic [1:0][11:0] pos_mv,
  input  wire logic [1:0][11:0] neg_mv,
  // Comparator results
  output logic      [1:0]       comp_raw = 2'h0
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int REF_MV = 1230;
  localparam int HYS_MV = 40;

  // Settles one clock after inputs move; an unpowered unit holds its last result
  always @(posedge sys_clk) begin
    for (int u = 0; u < 2; u++) begin
      int p;
      int h;
      p = ref_internal[u] ? REF_MV : int'(pos_mv[u]);
      h = hysteresis_on[u] ? HYS_MV : 0;
      if (pins_analog[u] && p > int'(neg_mv[u]) + h)
        comp_raw[u] <= 1'b1;
      else if (pins_analog[u] && p + h < int'(neg_mv[u]))
        comp_raw[u] <= 1'b0;
    end
  end
endmodule

// File: amp_comparator_control_tb.sv
/*
  Self-checking bench for amp_comparator_control with an integer reference model.
  Assumes analog_front_model drives comp_raw and the package gives the map.
*/
module amp_comparator_control_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals and reference state
  // ----------------------------------------------------------------
  logic             sys_clk = 1'b0;
  logic             rst_n   = 1'b0;
  logic             psel    = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite  = 1'b0;
  logic [11:0]      paddr   = 12'h000;
  logic [31:0]      pwdata  = 32'h0000_0000;
  logic [31:0]      prdata, rd;
  logic             pready, pslverr, route, err;
  logic [1:0]       comp_raw, amp_on, comp_on, pins_analog, ref_internal, ref_external, hysteresis_on;
  logic [1:0][11:0] pos_mv  = {12'h1F4, 12'h1F4};
  logic [1:0][11:0] neg_mv  = {12'hFFF, 12'hFFF};
  int               n_fail = 0, num_checks = 0, seed = 32'h0D4011D6;
  int               pin_m = 0, ctl_m[2] = '{0, 0}, flag_m[2] = '{0, 0}, hi_m[2] = '{0, 0};

  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;

  amp_comparator_control u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comp_raw(comp_raw), .amp_on(amp_on), .comp_on(comp_on), .pins_analog(pins_analog),
    .ref_internal(ref_internal), .ref_external(ref_external), .hysteresis_on(hysteresis_on),
    .amp0_extra_converter_route(route));

  analog_front_model u_front (.sys_clk(sys_clk), .pins_analog(pins_analog), .ref_internal(ref_internal),
    .hysteresis_on(hysteresis_on), .pos_mv(pos_mv), .neg_mv(neg_mv), .comp_raw(comp_raw));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [11:0] addr_of(input int idx);
    case (idx)
      0: return amp_comparator_pkg::PIN_SELECT_ADDR;
      1: return amp_comparator_pkg::CONTROL0_ADDR;
      default: return amp_comparator_pkg::CONTROL1_ADDR;
    endcase
  endfunction

  // One APB transfer, entered just after a rising edge; an idle edge follows
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for ready
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Register write that also updates the reference; a zero in the flag bit clears it
  task automatic wr_reg(input int idx, input logic [7:0] v);
    apb(1'b1, addr_of(idx), {24'h000000, v});
    if (idx == 0)
      pin_m = v;
    else begin
      ctl_m[idx-1] = v;
      if (!v[3])
        flag_m[idx-1] = 0;
    end
  endtask

  task automatic chk_reg(input int idx);
    logic [31:0] e;
    apb(1'b0, addr_of(idx), 32'h0000_0000);
    if (idx == 0)
      e = pin_m;
    else
      e = (ctl_m[idx-1] & (idx == 1 ? 8'hB1 : 8'hB0)) | (hi_m[idx-1] << 6) | (flag_m[idx-1] << 3);
    chk("register read", rd, e);
    chk("read error", err, 1'b0);
  endtask

  // Outputs lag the register by a cycle, so let one more edge land first
  task automatic chk_out;
    logic [1:0] a, c, v, p;
    @(posedge sys_clk);
    for (int u = 0; u < 2; u++) begin
      {a[u], c[u], v[u], p[u]} = 4'((pin_m >> (4 * (1 - u))) & 15);
    end
    chk("amp_on", amp_on, a);
    chk("comp_on", comp_on, c & ~a);
    chk("pins_analog", pins_analog, a | c);
    chk("ref_internal", ref_internal, (a | c) & v);
    chk("ref_external", ref_external, (a | c) & p & ~v);
    chk("hysteresis_on", hysteresis_on, {ctl_m[1][7], ctl_m[0][7]});
    chk("route", route, ctl_m[0][0]);
  endtask

  // Moves one comparator and predicts the flag from the selected edge mode
  task automatic drive(input int u, input int hi, input int w);
    int m;
    m = (ctl_m[u] >> 4) & 3;
    if ((m == 0 && hi != hi_m[u]) || (m == 1 && hi > hi_m[u]) || (m == 2 && hi < hi_m[u]))
      flag_m[u] = 1;
    hi_m[u] = hi;
    pos_mv[u] <= hi ? 12'h7D0 : 12'h1F4;
    repeat (w) @(posedge sys_clk);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int n[2];
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 3; i++)
      chk_reg(i);
    chk_out();
    // Random legal pin-select settings; software never forms a forbidden one
    repeat (24) begin
      for (int u = 0; u < 2; u++) begin
        do
          n[u] = $random(seed) & 15;
        while ((n[u][3:2] != 0 && n[u][1:0] == 0) || (n[u][3] && n[u][1:0] == 3));
      end
      wr_reg(0, 8'((n[0] << 4) | n[1]));
      chk_reg(0);
      chk_out();
    end
    // Read-only and reserved bits ignore writes
    wr_reg(1, 8'hFF);
    chk_reg(1);
    wr_reg(2, 8'hFF);
    chk_reg(2);
    chk_out();
    // Unmapped address is refused and leaves the pin-select register alone
    apb(1'b1, 12'h004, 32'h0000_00FF);
    chk("unmapped write error", err, 1'b1);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk("unmapped read", {rd[31:1], err}, 32'h0000_0001);
    chk_reg(0);
    // Every edge mode on both units, with a sticky flag and a write-one hold
    wr_reg(0, 8'h55);
    neg_mv <= {12'h3E8, 12'h3E8};
    for (int u = 0; u < 2; u++) begin
      for (int m = 0; m < 4; m++) begin
        wr_reg(u + 1, 8'(($random(seed) & 8'h81) | (m << 4)));
        drive(u, 1, 5);
        chk_reg(u + 1);
        wr_reg(u + 1, 8'(ctl_m[u] | 8'h08));
        drive(u, 0, 5);
        chk_reg(u + 1);
        chk_out();
      end
    end
    // Clear write lands on the very edge the hardware sets the flag
    wr_reg(1, 8'h00);
    drive(0, 1, 2);
    wr_reg(1, 8'h00);
    flag_m[0] = 1;
    chk_reg(1);
    wrap_up();
  end

  // Watchdog
  initial begin
    #400000;
    n_fail++;
    wrap_up();
  end
endmodule
